// [verilog/tdm_timing_front_end.sv]
/*
 * Timing front end of a TDM switch: locks a frame counter to the
 * incoming frame pulse, receives the serial streams and generates the
 * output clocks and frame pulses for downstream devices.
 * Assumes the link clock and pins come from a backplane timing source;
 * all configuration inputs are static while the link runs.
 */
// Implementation choices: the register offsets and the APB slave port.
// Functional notes
// R1 - Accept 8 kHz 61/122/244 ns frame pulse
// R2 - Source uses 61 ns pulse at 16 Mbps
// R3 - Active low pulse unless polarity bit set
// R4 - Format bit selects leading-edge pulse format
// R5 - Input clock 4.096, 8.192 or 16.384 MHz
// R6 - Divided mode: clock twice fastest stream rate; source lets the clock equal stream rates above 2 Mbps
// R7 - Multiplied mode: clock twice fastest input rate; source lets the clock equal stream rates above 2 Mbps here too
// R8 - Any 16 Mbps stream needs 16 MHz clock
// R9 - Falling edge marks boundary unless edge bit
// R10 - Per-stream receive rate 2, 4, 8, 16 Mbps
// R11 - First three output clocks fixed 4/8/16 MHz; code outputs the input clock for any above the input rate
// R12 - Fourth clock programmable, 32 MHz when multiplied; code outputs the input clock instead
// R13 - Three fixed frame pulses matching fixed clocks
// R14 - Fourth frame pulse follows fourth clock rate
// R15 - Three offset pulses, programmable channel displacement
// R16 - Board ties both low-rate strap pins together
// R17 - Outputs derive from, locked to, input clock
`timescale 1ns/100ps
module tdm_timing_front_end import tdm_pkg::*; #(
    parameter int N = NUM_STREAMS
) (
    // Link
    tdm_link_if.device link,
    input wire logic presetn,
    // Static configuration
    input wire logic fp_polarity_sel,
    input wire logic fp_format_sel,
    input wire logic clk_edge_sel,
    input wire logic [1:0] clk_rate_sel,
    input wire logic mult_clock_mode,
    input wire logic [1:0] ck3_rate_sel,
    input wire logic [2:0][6:0] offset_channels,
    input wire logic [N-1:0][1:0] input_stream_ctrl,
    // Timing outputs
    output logic [3:0] timing_clock_outputs,
    output logic [3:0] frame_pulse_outputs,
    output logic [2:0] offset_frame_pulses,
    // Status and received data
    output logic frame_locked,
    output logic [CNT_W-1:0] frame_tick,
    output logic [N-1:0][7:0] rx_byte,
    output logic [N-1:0] rx_valid
);
    typedef struct packed {
        logic fp_s1;
        logic fp_s2;
        logic [N-1:0] st_s1;
        logic [N-1:0] st_s2;
        logic [1:0] strap_s1;
        logic [1:0] strap_s2;
        logic fp_prev;
        logic [2:0] run;
        logic [CNT_W-1:0] cnt;
        logic locked;
        logic [N-1:0][7:0] shreg;
        logic [N-1:0][7:0] rx_byte;
        logic [N-1:0] rx_valid;
        logic [3:0] fpo;
        logic [2:0] offp;
    } dev_state_t;

    dev_state_t s;
    dev_state_t next_s;
    logic link_clk;
    logic [1:0] crate;
    logic [1:0] ck3_code;
    logic [3:0][1:0] ck_code;

    // ------------------------------------------------------------
    // Clock edge and rate selection
    // ------------------------------------------------------------
    // The selected input edge becomes the rising edge of the internal
    // clock. Changing the edge bit while running may glitch the clock,
    // which is why it is a static setting.
    assign link_clk = link.timing_clock_in ^ ~clk_edge_sel; // see R9

    always_comb begin
        // Tied strap pins, once synchronised, force the 4.096 MHz clock mode.
        if (&s.strap_s2) begin
            crate = CLK_4M; // see R16
        end else if (clk_rate_sel > CLK_16M) begin
            crate = CLK_16M;
        end else begin
            crate = clk_rate_sel; // see R5
        end
        ck3_code = mult_clock_mode ? CK3_32M : ck3_rate_sel; // see R12
        if (!mult_clock_mode && ck3_rate_sel > CLK_16M) begin
            ck3_code = CLK_16M;
        end
        ck_code = {ck3_code, CLK_16M, 2'h1, CLK_4M}; // see R11
    end

    // ------------------------------------------------------------
    // Output clocks
    // ------------------------------------------------------------
    // A clock slower than the input is a frame counter bit; one at or
    // above the input rate is the input clock itself, since no
    // register can toggle faster than its own clock.
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            if (ck_code[k] < crate) begin
                timing_clock_outputs[k] = s.cnt[2'(crate - ck_code[k] - 2'h1)]; // see R17
            end else begin
                timing_clock_outputs[k] = link.timing_clock_in; // see R11, R12
            end
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [11:0] flen;
        logic [CNT_W-1:0] last;
        logic fp_act;
        logic align;
        logic [CNT_W-1:0] target;
        logic [2:0] sh;
        logic [CNT_W-1:0] mask;
        logic [CNT_W-1:0] bi;
        logic [CNT_W-1:0] half;
        logic [CNT_W-1:0] start;
        logic act;
        flen = FRAME_TICKS_4M << crate;
        last = CNT_W'(flen - 12'h001);
        fp_act = 1'b0;
        align = 1'b0;
        target = FP_SYNC_LAT;
        sh = '0;
        mask = '0;
        bi = '0;
        half = '0;
        start = '0;
        act = 1'b0;
        next_s = s;
        // Pins pass two flip-flops before anything looks at them.
        next_s.fp_s1 = link.frame_pulse_in;
        next_s.fp_s2 = s.fp_s1;
        next_s.st_s1 = link.serial_in_streams;
        next_s.st_s2 = s.st_s1;
        next_s.strap_s1 = {link.low_rate_clock_sel_a, link.low_rate_clock_sel_b};
        next_s.strap_s2 = s.strap_s1;

        fp_act = fp_polarity_sel ? s.fp_s2 : ~s.fp_s2; // see R3
        next_s.fp_prev = fp_act;
        if (!fp_act) begin
            next_s.run = '0;
        end else if (s.run != 3'h7) begin
            next_s.run = s.run + 3'h1; // see R1
        end
        if (fp_format_sel) begin
            // Pulse starts at the boundary: lock on its leading edge.
            align = fp_act && !s.fp_prev; // see R4
        end else begin
            // Pulse straddles the boundary: its middle is the boundary.
            align = !fp_act && s.fp_prev; // see R1
            target = FP_SYNC_LAT + CNT_W'(s.run >> 1);
        end

        next_s.cnt = (s.cnt >= last) ? '0 : s.cnt + 1'b1;
        if (align) begin
            next_s.locked = (next_s.cnt == target);
            next_s.cnt = target; // see R17
        end

        for (int i = 0; i < N; i++) begin
            next_s.rx_valid[i] = 1'b0;
            if (input_stream_ctrl[i] <= crate + 2'h1 || crate == CLK_16M) begin
                sh = 3'h1 + 3'(crate) - 3'(input_stream_ctrl[i]); // see R10
                mask = CNT_W'((12'h001 << sh) - 12'h001);
                // Stream bits trail the counter by the synchroniser depth.
                bi = s.cnt - FP_SYNC_LAT + 1'b1;
                // Sample each bit on the last tick of its bit cell.
                if ((bi & mask) == mask) begin
                    next_s.shreg[i] = {s.shreg[i][6:0], s.st_s2[i]}; // see R10
                    if (3'(bi >> sh) == BYTE_LAST) begin
                        next_s.rx_byte[i] = {s.shreg[i][6:0], s.st_s2[i]};
                        next_s.rx_valid[i] = 1'b1;
                    end
                end
            end
        end

        // Frame pulses are active low, one output clock wide, centred.
        for (int k = 0; k < 4; k++) begin
            if (ck_code[k] < crate) begin
                half = CNT_W'(12'h001 << (crate - ck_code[k] - 2'h1));
                act = (s.cnt >= last - half + 1'b1) || (s.cnt < half);
            end else begin
                act = (s.cnt == last);
            end
            next_s.fpo[k] = ~act; // see R13, R14
        end
        for (int j = 0; j < 3; j++) begin
            start = CNT_W'(offset_channels[j] * (CH_TICKS_4M << crate));
            next_s.offp[j] = ~(s.cnt == start); // see R15
        end
    end

    always_ff @(posedge link_clk or negedge presetn) begin
        if (!presetn) begin
            s <= '{fp_s1: 1'b1, fp_s2: 1'b1, fpo: 4'hF, offp: 3'h7, default: '0};
        end else begin
            s <= next_s;
        end
    end

    assign frame_pulse_outputs = s.fpo;
    assign offset_frame_pulses = s.offp;
    assign frame_locked = s.locked;
    assign frame_tick = s.cnt;
    assign rx_byte = s.rx_byte;
    assign rx_valid = s.rx_valid;

endmodule // tdm_timing_front_end

// [verilog/tdm_pkg.sv]
/*
 * Shared constants of the TDM timing front end and of its timing source.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package tdm_pkg;
    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int NUM_STREAMS = 32;
    localparam int CNT_W = 11;
    // Ticks of a 4.096 MHz input clock in one 125 us frame.
    localparam logic [11:0] FRAME_TICKS_4M = 12'h0200;
    // Ticks per 8.192 Mbps channel at a 4.096 MHz input clock.
    localparam logic [10:0] CH_TICKS_4M = 11'h004;
    // Ticks from a pin change to the frame counter that sees it.
    localparam logic [10:0] FP_SYNC_LAT = 11'h003;
    localparam logic [2:0] BYTE_LAST = 3'h7;
    // ------------------------------------------------------------
    // Rate and width codes
    // ------------------------------------------------------------
    localparam logic [1:0] RATE_2M = 2'h0;
    localparam logic [1:0] RATE_4M = 2'h1;
    localparam logic [1:0] RATE_8M = 2'h2;
    localparam logic [1:0] RATE_16M = 2'h3;
    localparam logic [1:0] CLK_4M = 2'h0;
    localparam logic [1:0] CLK_16M = 2'h2;
    localparam logic [1:0] CK3_32M = 2'h3;
    // Frame pulse widths, and their width codes.
    localparam int FP_W61_NS = 61;
    localparam int FP_W122_NS = 122;
    localparam int FP_W244_NS = 244;
    localparam logic [1:0] FPW_61 = 2'h0;
    localparam logic [1:0] FPW_244 = 2'h2;
    // ------------------------------------------------------------
    // Timing source register map (APB, byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] SRC_CTRL = 8'h00;
    localparam logic [7:0] SRC_RATE_LO = 8'h04;
    localparam logic [7:0] SRC_RATE_HI = 8'h08;
    localparam logic [7:0] SRC_PATTERN = 8'h0C;
    localparam logic [7:0] SRC_STATUS = 8'h10;
    localparam int CTRL_EN = 0;
    localparam int CTRL_CLK_LSB = 1;
    localparam int CTRL_FPW_LSB = 3;
    localparam int CTRL_POL = 5;
    localparam int CTRL_FMT = 6;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0004;
    localparam logic [7:0] PATTERN_RESET = 8'hA5;
endpackage

// [verilog/tdm_link_if.sv]
/*
 * Backplane timing link between the timing source and the front end.
 * Assumes the source drives every wire; the device only listens.
 */
`timescale 1ns/100ps
interface tdm_link_if #(parameter int N = 32);
    logic timing_clock_in;
    logic frame_pulse_in;
    logic [N-1:0] serial_in_streams;
    logic low_rate_clock_sel_a;
    logic low_rate_clock_sel_b;
    modport source (
        output timing_clock_in, frame_pulse_in, serial_in_streams,
        output low_rate_clock_sel_a, low_rate_clock_sel_b
    );
    modport device (
        input timing_clock_in, frame_pulse_in, serial_in_streams,
        input low_rate_clock_sel_a, low_rate_clock_sel_b
    );
endinterface

// [verilog/tdm_timing_source.sv]
/*
 * Backplane timing source: divides pclk into the link clock and drives
 * the frame pulse and all serial streams. Software sets it over APB.
 * Assumes a single APB master; the link clock is a plain output.
 */
`timescale 1ns/100ps
module tdm_timing_source import tdm_pkg::*; #(
    parameter int N = NUM_STREAMS,
    parameter int CLK_HALF = 2
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Link
    tdm_link_if.source link
);
    typedef struct packed {
        logic [7:0] div;
        logic lclk;
        logic [CNT_W-1:0] cnt;
        logic fp;
        logic [N-1:0] st;
        logic [31:0] ctrl;
        logic [N-1:0][1:0] rate;
        logic [7:0] pattern;
        logic [31:0] rdata;
        logic [15:0] frames;
    } src_state_t;

    src_state_t s;
    src_state_t next_s;
    logic mapped;

    always_comb begin
        mapped = paddr inside {SRC_CTRL, SRC_RATE_LO, SRC_RATE_HI, SRC_PATTERN, SRC_STATUS};
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [1:0] smax;
        logic [1:0] ceff;
        logic [1:0] fpw;
        logic [2:0] w;
        logic [11:0] flen;
        logic [CNT_W-1:0] nc;
        logic [2:0] sh;
        logic [CNT_W-1:0] bi;
        logic act;
        smax = RATE_2M;
        ceff = s.ctrl[CTRL_CLK_LSB +: 2];
        fpw = s.ctrl[CTRL_FPW_LSB +: 2];
        w = 3'h1;
        flen = FRAME_TICKS_4M;
        nc = '0;
        sh = '0;
        bi = '0;
        act = 1'b0;
        next_s = s;
        for (int i = 0; i < N; i++) begin
            if (s.rate[i] > smax) begin
                smax = s.rate[i];
            end
        end
        // The clock runs at the fastest stream rate at least, and never below 4.096 MHz.
        if (smax != RATE_2M && (smax - 2'h1) > ceff) begin // see R6, R7
            ceff = smax - 2'h1;
        end
        if (smax == RATE_16M) begin
            ceff = CLK_16M; // see R8
            fpw = FPW_61; // see R2
        end
        if (fpw > FPW_244) begin
            fpw = FPW_244;
        end
        w = 3'((4'h1 << fpw) >> (CLK_16M - ceff));
        if (w == 3'h0) begin
            w = 3'h1;
        end
        flen = FRAME_TICKS_4M << ceff;
        if (s.ctrl[CTRL_EN]) begin
            if (s.div == 8'(CLK_HALF - 1)) begin
                next_s.div = '0;
                next_s.lclk = ~s.lclk;
            end else begin
                next_s.div = s.div + 8'h01;
            end
            // Pins move one pclk after the link clock rises, clear of both edges.
            if (s.lclk && s.div == '0) begin
                nc = (12'(s.cnt) == flen - 12'h001) ? '0 : s.cnt + 1'b1;
                next_s.cnt = nc;
                if (s.ctrl[CTRL_FMT]) begin
                    act = nc < CNT_W'(w);
                end else begin
                    act = (12'(nc) >= flen - 12'(w - (w >> 1))) || (nc < CNT_W'(w >> 1));
                end
                next_s.fp = s.ctrl[CTRL_POL] ? act : ~act; // see R1
                for (int i = 0; i < N; i++) begin
                    sh = 3'h1 + 3'(ceff) - 3'(s.rate[i]);
                    bi = nc >> sh;
                    next_s.st[i] = s.pattern[BYTE_LAST - bi[2:0]];
                end
                if (nc == '0) begin
                    next_s.frames = s.frames + 16'h0001;
                end
            end
        end
        if (psel && !penable) begin
            case (paddr)
                SRC_CTRL: next_s.rdata = s.ctrl;
                SRC_RATE_LO: next_s.rdata = s.rate[15:0];
                SRC_RATE_HI: next_s.rdata = s.rate[N-1:16];
                SRC_PATTERN: next_s.rdata = {24'h00_0000, s.pattern};
                SRC_STATUS: next_s.rdata = {14'h0000, ceff, s.frames};
                default: next_s.rdata = '0;
            endcase
        end
        if (psel && penable && pwrite && mapped) begin
            case (paddr)
                SRC_CTRL: next_s.ctrl = pwdata;
                SRC_RATE_LO: next_s.rate[15:0] = pwdata;
                SRC_RATE_HI: next_s.rate[N-1:16] = pwdata;
                SRC_PATTERN: next_s.pattern = pwdata[7:0];
                default: next_s.ctrl = s.ctrl;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '{ctrl: CTRL_RESET, pattern: PATTERN_RESET, fp: 1'b1, default: '0};
        end else begin
            s <= next_s;
        end
    end

    assign prdata = s.rdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign link.timing_clock_in = s.lclk;
    assign link.frame_pulse_in = s.fp;
    assign link.serial_in_streams = s.st;
    // Both low-rate strap pins carry one level.
    assign link.low_rate_clock_sel_a = (s.ctrl[CTRL_CLK_LSB +: 2] == CLK_4M); // see R16
    assign link.low_rate_clock_sel_b = (s.ctrl[CTRL_CLK_LSB +: 2] == CLK_4M); // see R16

endmodule // tdm_timing_source

// [testbench/tdm_link_monitor.sv]
/*
 * Checker for the backplane timing link between source and front end.
 * Assumes the bench top wires in the link signals and the reset.
 */
`timescale 1ns/100ps
module tdm_link_monitor #(
    parameter int N = 32
) (
    // Link
    input wire logic timing_clock_in,
    input wire logic frame_pulse_in,
    input wire logic [N-1:0] serial_in_streams,
    input wire logic low_rate_clock_sel_a,
    input wire logic low_rate_clock_sel_b,
    // Reset
    input wire logic presetn
);
    // ------------------------------------------------------------
    // Run lengths
    // ------------------------------------------------------------
    // Early phases straddle reconfiguration after reset, so they are skipped.
    logic fp_q;
    logic [2:0] nchg;
    logic [12:0] run;
    logic [12:0] last;
    logic [N-1:0] st_q;
    logic [N-1:0] st_qq;
    logic [N-1:0] st_n;
    logic fast_seen;
    logic chg;
    logic live;
    logic fast;
    assign chg = frame_pulse_in != fp_q;
    assign live = nchg == 3'h6;
    assign fast = |((serial_in_streams ^ st_q) & (st_q ^ st_qq));
    always_ff @(posedge timing_clock_in or negedge presetn) begin
        if (!presetn) begin
            fp_q <= 1'b1;
            nchg <= 3'h0;
            run <= 13'h0000;
            last <= 13'h0000;
            st_q <= '0;
            st_qq <= '0;
            fast_seen <= 1'b0;
        end else begin
            fp_q <= frame_pulse_in;
            st_q <= serial_in_streams;
            st_qq <= st_q;
            run <= chg ? 13'h0001 : run + 13'h0001;
            if (chg) last <= run;
            if (chg && !live) nchg <= nchg + 3'h1;
            if (fast) fast_seen <= 1'b1;
        end
    end
    always_ff @(negedge timing_clock_in or negedge presetn) begin
        if (!presetn) st_n <= '0;
        else st_n <= serial_in_streams;
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge timing_clock_in); endclocking
    default disable iff (!presetn);
    a_straps_tied: assert property (low_rate_clock_sel_a == low_rate_clock_sel_b)
        else $error("low-rate strap pins differ");
    a_pulse_ends: assert property (chg && live && run >= 13'h01FC |-> ##[1:4] chg)
        else $error("frame pulse too long");
    a_frame_length: assert property (chg && live && run >= 13'h01FC
        |-> (run + last) inside {13'h0200, 13'h0400, 13'h0800})
        else $error("frame period wrong");
    a_low_rate_frame: assert property (chg && live && low_rate_clock_sel_a
        && run >= 13'h01FC |-> run + last == 13'h0200)
        else $error("low-rate frame period wrong");
    a_fast_clock: assert property (chg && live && fast_seen
        && run >= 13'h01FC |-> run + last == 13'h0800)
        else $error("fast stream without fast clock");
    a_fast_pulse: assert property (chg && live && fast_seen
        && run < 13'h01FC |-> run == 13'h0001)
        else $error("fast stream with wide pulse");
    a_rate_limit: assert property (low_rate_clock_sel_a |-> !fast)
        else $error("stream faster than half the clock");
    a_stream_timing: assert property (serial_in_streams == st_n)
        else $error("stream changed after falling edge");
    c_fast_frame: cover property (chg && live && fast_seen && run >= 13'h01FC);
    c_low_frame: cover property (chg && live && low_rate_clock_sel_a && run >= 13'h01FC);
    c_fast_stream: cover property (fast);
endmodule // tdm_link_monitor

// [testbench/testbench.sv]
/*
 * Self-checking bench: timing source and front end joined by the link.
 * Assumes the package, interface and both design modules compile first.
 */
`timescale 1ns/100ps
module testbench import tdm_pkg::*;;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic fp_polarity_sel = 1'b0;
    logic fp_format_sel = 1'b0;
    logic clk_edge_sel = 1'b0;
    logic mult_clock_mode = 1'b0;
    logic [1:0] clk_rate_sel = 2'h0;
    logic [1:0] ck3_rate_sel = 2'h1;
    logic [2:0][6:0] offset_channels = '0;
    logic [31:0][1:0] input_stream_ctrl = '0;
    logic [3:0] timing_clock_outputs;
    logic [3:0] frame_pulse_outputs;
    logic [2:0] offset_frame_pulses;
    logic frame_locked;
    logic [CNT_W-1:0] frame_tick;
    logic [31:0][7:0] rx_byte;
    logic [31:0] rx_valid;
    logic [6:0] pulses;
    int fails = 0;
    int n_tests = 0;
    int ck_cnt [4];
    assign pulses = {offset_frame_pulses, frame_pulse_outputs};
    always #10 pclk = ~pclk;
    tdm_link_if #(.N(32)) lk ();
    tdm_timing_source #(.N(32), .CLK_HALF(2)) i_tdm_timing_source (.pclk, .presetn,
        .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .link(lk));
    tdm_timing_front_end #(.N(32)) i_tdm_timing_front_end (.link(lk), .presetn,
        .fp_polarity_sel, .fp_format_sel, .clk_edge_sel, .clk_rate_sel, .mult_clock_mode,
        .ck3_rate_sel, .offset_channels, .input_stream_ctrl, .timing_clock_outputs,
        .frame_pulse_outputs, .offset_frame_pulses, .frame_locked, .frame_tick, .rx_byte,
        .rx_valid);
    tdm_link_monitor #(.N(32)) i_tdm_link_monitor (.timing_clock_in(lk.timing_clock_in),
        .frame_pulse_in(lk.frame_pulse_in), .serial_in_streams(lk.serial_in_streams),
        .low_rate_clock_sel_a(lk.low_rate_clock_sel_a),
        .low_rate_clock_sel_b(lk.low_rate_clock_sel_b), .presetn(presetn));
    for (genvar g = 0; g < 4; g++) begin : g_ck
        always @(posedge timing_clock_outputs[g]) ck_cnt[g]++;
    end
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string nm, input logic [31:0] s, input logic [31:0] x);
        n_tests++;
        if (s !== x) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, x, s);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) fails++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rst_on;
        @(posedge pclk);
        presetn <= 1'b0;
    endtask
    task automatic rst_off;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
    endtask
    // Samples after the pin change and before the falling edge.
    task automatic tk;
        @(posedge lk.timing_clock_in);
        #30;
    endtask
    task automatic cfg(input logic [1:0] code, input logic [1:0] fpw, input logic pol,
            input logic fmt, input logic [31:0] rlo);
        wr(SRC_RATE_LO, rlo);
        wr(SRC_RATE_HI, 32'h0000_0000);
        wr(SRC_PATTERN, 32'h0000_005A);
        wr(SRC_CTRL, {25'h0, fmt, pol, fpw, code, 1'b1});
    endtask
    task automatic wait_lock(input int lim);
        int n = 0;
        while (frame_locked !== 1'b1 && n < lim) begin
            tk;
            n++;
        end
        check("frame_locked", frame_locked, 1);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        logic [31:0] r;
        logic e;
        rst_on;
        rst_off;
        apb(1'b0, SRC_CTRL, 32'h0, r, e);
        check("ctrl reset", r, CTRL_RESET);
        apb(1'b0, SRC_PATTERN, 32'h0, r, e);
        check("pattern reset", r, {24'h0, PATTERN_RESET});
        apb(1'b1, SRC_PATTERN, 32'h0000_00C3, r, e);
        check("pattern wr err", e, 1'b0);
        apb(1'b0, SRC_PATTERN, 32'h0, r, e);
        check("pattern", r, 32'h0000_00C3);
        apb(1'b1, 8'h40, 32'hFFFF_FFFF, r, e);
        check("unmapped wr err", e, 1'b1);
        apb(1'b0, 8'h40, 32'h0, r, e);
        check("unmapped err", e, 1'b1);
        check("unmapped data", r, 32'h0);
        apb(1'b1, SRC_STATUS, 32'hFFFF_FFFF, r, e);
        check("status wr err", e, 1'b0);
        apb(1'b0, SRC_STATUS, 32'h0, r, e);
        check("status code", r[17:16], CLK_16M);
        $display("test regs done");
    endtask
    task automatic t_sync(input logic pol, input logic fmt, input logic edg);
        int n = 0;
        rst_on;
        fp_polarity_sel <= pol;
        fp_format_sel <= fmt;
        clk_edge_sel <= edg;
        clk_rate_sel <= CLK_4M;
        input_stream_ctrl <= '0;
        rst_off;
        cfg(CLK_4M, FPW_244, pol, fmt, 32'h0);
        wait_lock(2048);
        while (lk.frame_pulse_in !== pol && n < 1024) begin
            tk;
            n++;
        end
        repeat (16) tk;
        check("phase", frame_tick >= 11'h008 && frame_tick <= 11'h018, 1'b1);
        check("rx byte", rx_byte[5], 8'h5A);
        $display("test sync done");
    endtask
    task automatic t_rates(input logic m);
        int fall [7] = '{default: 0};
        int idx [3] = '{default: 0};
        int rxc [4] = '{default: 0};
        logic [6:0] prev;
        rst_on;
        fp_polarity_sel <= 1'b0;
        fp_format_sel <= 1'b0;
        clk_edge_sel <= 1'b0;
        clk_rate_sel <= CLK_16M;
        mult_clock_mode <= m;
        offset_channels <= {7'h64, 7'h05, 7'h02};
        input_stream_ctrl <= {56'h0, RATE_16M, RATE_8M, RATE_4M, RATE_2M};
        rst_off;
        cfg(CLK_16M, FPW_61, 1'b0, 1'b0, 32'h0000_00E4);
        wait_lock(8192);
        tk;
        foreach (ck_cnt[k]) ck_cnt[k] = 0;
        prev = pulses;
        for (int t = 0; t < 2048; t++) begin
            tk;
            for (int k = 0; k < 7; k++) begin
                if (prev[k] === 1'b1 && pulses[k] === 1'b0) begin
                    fall[k]++;
                    if (k > 3) idx[k-4] = t;
                end
            end
            for (int s = 0; s < 4; s++) begin
                if (rx_valid[s] === 1'b1) begin
                    rxc[s]++;
                    check("rx byte", rx_byte[s], 8'h5A);
                end
            end
            prev = pulses;
        end
        for (int k = 0; k < 4; k++) check("channels", rxc[k], 32 << k);
        for (int k = 0; k < 7; k++) check("pulse count", fall[k], 1);
        check("ck0", ck_cnt[0], FRAME_TICKS_4M);
        check("ck1", ck_cnt[1], FRAME_TICKS_4M << 1);
        check("ck2", ck_cnt[2], FRAME_TICKS_4M << 2);
        check("ck3", ck_cnt[3], FRAME_TICKS_4M << (m ? 2 : 1));
        check("fp3 count", fall[3], 1);
        check("gap 1", (idx[1] - idx[0]) & 2047, 3 * (CH_TICKS_4M << 2));
        check("gap 2", (idx[2] - idx[0]) & 2047, 98 * (CH_TICKS_4M << 2));
        $display("test rates done");
    endtask
    initial begin
        t_regs;
        t_sync(1'b0, 1'b0, 1'b0);
        t_sync(1'b1, 1'b0, 1'b1);
        t_sync(1'b0, 1'b1, 1'b0);
        t_rates(1'b0);
        t_rates(1'b1);
        close_out;
    end
    initial begin
        #2_000_000;
        fails++;
        close_out;
    end
endmodule // testbench
